// *** include/ftbs_pkg.sv ***
// Purpose: constants and types of the sequencer
// Assumes: 200 MHz pclk, elapsed time kept in tenths of a second
// Notes: all windows are whole tenths; elapsed counters saturate, never wrap
package ftbs_pkg;

    // =========================================================
    // clock and time base
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TIME_W = 18;

    // =========================================================
    // windows, in tenths of a second
    localparam int SEP_HOLD_TENTHS = 14;        // 1.4 s into third base
    localparam int RESTART_TENTHS = 150000;     // 4 h 10 min
    localparam int BURNER_LO_TENTHS = 480;      // 48 s
    localparam int BURNER_HI_TENTHS = 4969;     // 8 min 16.9 s
    localparam int EIGHTH_TENTHS = 50030;       // 1 h 23 min 23 s
    localparam int ALT8_TENTHS = 56348;         // 1 h 33 min 54.8 s
    localparam int NINTH_T6_TENTHS = 66800;     // 1 h 51 min 20 s
    localparam int NINTH_T5_TENTHS = 227200;    // 6 h 18 min 40 s
    localparam int SETTLE_TENTHS = 100;         // thrust settling delay

    // =========================================================
    // register map, byte addresses
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] EVENT_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] ELAPSED_OFS = 8'h0c;
    localparam logic [7:0] HIST_OFS = 8'h10;

    // control register fields
    localparam int CTRL_OB_ARM_BIT = 0;
    localparam int CTRL_OX_ARM_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // event register fields, write one to signal
    localparam int EV_SOLVED_BIT = 0;
    localparam int EV_ALT6_DONE_BIT = 1;
    localparam int EV_VEL_CUT_BIT = 2;
    localparam int EV_ENG_CUT_BIT = 3;
    localparam int EV_THRUST_LOSS_BIT = 4;

    // pin input vector positions
    localparam int PIN_N = 9;
    localparam int PIN_OB_CUT = 0;
    localparam int PIN_S2_CUT = 1;
    localparam int PIN_S2_OUT = 2;
    localparam int PIN_SEP_A = 3;
    localparam int PIN_SEP_B = 4;
    localparam int PIN_EO_A = 5;
    localparam int PIN_EO_B = 6;
    localparam int PIN_BURNER = 7;
    localparam int PIN_INHIBIT = 8;

    // =========================================================
    // current time base, one-hot
    typedef enum logic [10:0] {
        FTBS_PRE  = 11'h001,
        FTBS_B3   = 11'h002,
        FTBS_B4   = 11'h004,
        FTBS_B4A  = 11'h008,
        FTBS_B5   = 11'h010,
        FTBS_B6   = 11'h020,
        FTBS_B6A  = 11'h040,
        FTBS_B7   = 11'h080,
        FTBS_B8   = 11'h100,
        FTBS_B8A  = 11'h200,
        FTBS_B9   = 11'h400
    } ftbs_base_e;

endpackage

// *** hdl/ftbs_vote.sv ***
// Purpose: two-of-four vote over inputs latched per base
// Assumes: inputs already in the pclk domain
// Notes: a set arriving with the clear is kept, so no event is lost
`timescale 1ns/100ps
module ftbs_vote #(
    parameter int N = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic [N-1:0] in_set,
    output logic vote
);

    // =========================================================
    // population count
    function automatic int ftbs_ones(input logic [N-1:0] v);
        int n;
        n = 0;
        for (int i = 0; i < N; i++) begin
            n = n + int'(v[i]);
        end
        return n;
    endfunction

    logic [N-1:0] held_reg;
    logic [N-1:0] held_next;

    // latch each input until the next base start [R20]
    assign held_next = (clear ? '0 : held_reg) | in_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_reg <= '0;
        end else begin
            held_reg <= held_next;
        end
    end

    assign vote = ftbs_ones(held_reg) >= 2;   // [R20]

endmodule

// *** hdl/ftbs_sequencer.sv ***
// Purpose: decides when the third to ninth flight time bases begin
// Assumes: APB slave with zero wait states, pins async to pclk
// Notes: elapsed time runs in tenths of a second from a tick divider
//
// How it works
// (R1) ox arm, then s2 cutoff or engines out starts base 4
// (R2) base 4 start pulses the second stage cutoff command
// (R3) separation request A or B starts the early staging base
// (R4) separation requests ignored before 1.4 s in base 3
// (R5) any two of four stage three events start base 5
// (R6) base 5 start pulses the third stage cutoff command
// (R7) base 6 needs solution, 4 h 10 min in base 5, no inhibit
// (R8) burner fault within 48 s to 496.9 s enters alt base, then back
// (R9) after settling, any two of four events start base 7
// (R10) base 7 start pulses the third stage cutoff command
// (R11) base 8 needs base 7, window since base 6, no inhibit
// (R12) alt 8 needs no base 6, no inhibit, window since solution
// (R13) inhibit held keeps the sequencer in base 5
// (R14) after settling in base 8 or alt 8, two of four start base 9
// (R15) base 7 without 8 allows base 9 a window after base 6
// (R16) no base 6, 8 or alt 8: base 9 a window after base 5
// (R17) base 9 start pulses the third stage cutoff command
// (R18) base 3 refused unless outboard depletion cutoff is armed
// (R19) one base identifier, elapsed counter cleared on each start
// (R20) vote inputs latch within a base and clear at next start
`timescale 1ns/100ps
module ftbs_sequencer #(
    parameter int TICK_CYCLES = ftbs_pkg::TICK_CYCLES,
    parameter int RESTART_TENTHS = ftbs_pkg::RESTART_TENTHS,
    parameter int EIGHTH_TENTHS = ftbs_pkg::EIGHTH_TENTHS,
    parameter int ALT8_TENTHS = ftbs_pkg::ALT8_TENTHS,
    parameter int NINTH_T6_TENTHS = ftbs_pkg::NINTH_T6_TENTHS,
    parameter int NINTH_T5_TENTHS = ftbs_pkg::NINTH_T5_TENTHS,
    parameter int SETTLE_TENTHS = ftbs_pkg::SETTLE_TENTHS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ob_cutoff_in,
    input wire logic s2_cutoff_in,
    input wire logic s2_engines_out_in,
    input wire logic sep_req_a_in,
    input wire logic sep_req_b_in,
    input wire logic engine_out_a_in,
    input wire logic engine_out_b_in,
    input wire logic burner_fault_in,
    input wire logic restart_inhibit_in,
    output logic s2_cutoff_cmd,
    output logic s3_cutoff_cmd,
    output logic base_start,
    output logic [10:0] base_onehot
);

    localparam int TW = ftbs_pkg::TIME_W;
    localparam int PN = ftbs_pkg::PIN_N;

    // =========================================================
    // elaboration checks
    generate
        if (TICK_CYCLES < 2) begin : g_bad_tick
            $error("tick divider needs at least two cycles");
        end
        if (NINTH_T5_TENTHS >= (1 << TW)) begin : g_bad_time
            $error("time window exceeds the elapsed counter width");
        end
    endgenerate

    // saturating tick count, shared by all elapsed counters
    function automatic logic [TW-1:0] ftbs_count(
        input logic [TW-1:0] v, input logic tick);
        if (tick && v != {TW{1'b1}}) begin
            return v + TW'(1);
        end
        return v;
    endfunction

    // true once a counter has reached a window in tenths
    function automatic logic ftbs_reached(
        input logic [TW-1:0] v, input int lim);
        return int'(v) >= lim;
    endfunction

    // =========================================================
    // pin synchronisers; only the second stage is read
    logic [PN-1:0] pin_raw;
    logic [PN-1:0] pin_meta_reg;
    logic [PN-1:0] pin_reg;

    assign pin_raw = {restart_inhibit_in, burner_fault_in, engine_out_b_in,
                      engine_out_a_in, sep_req_b_in, sep_req_a_in,
                      s2_engines_out_in, s2_cutoff_in, ob_cutoff_in};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= '0;
            pin_reg <= '0;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_reg <= pin_meta_reg;
        end
    end

    wire ob_cut = pin_reg[ftbs_pkg::PIN_OB_CUT];
    wire s2_cut = pin_reg[ftbs_pkg::PIN_S2_CUT];
    wire s2_out = pin_reg[ftbs_pkg::PIN_S2_OUT];
    wire sep_any = pin_reg[ftbs_pkg::PIN_SEP_A] | pin_reg[ftbs_pkg::PIN_SEP_B];
    wire eo_a = pin_reg[ftbs_pkg::PIN_EO_A];
    wire eo_b = pin_reg[ftbs_pkg::PIN_EO_B];
    wire burner = pin_reg[ftbs_pkg::PIN_BURNER];
    wire inhibit = pin_reg[ftbs_pkg::PIN_INHIBIT];

    // =========================================================
    // tenth-second tick divider
    logic [31:0] div_reg;
    logic tick_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (div_reg == 32'(TICK_CYCLES - 1));
            div_reg <= (div_reg == 32'(TICK_CYCLES - 1)) ? '0 : div_reg + 1;
        end
    end

    // =========================================================
    // APB slave: answer in the first access cycle
    logic [1:0] ctrl_reg;
    logic [31:0] rdata_reg;
    logic ready_reg;
    logic err_reg;
    logic [4:0] ev_reg;
    ftbs_pkg::ftbs_base_e base_reg;
    ftbs_pkg::ftbs_base_e base_next;
    logic [TW-1:0] el_reg;
    logic [3:0] hist_reg;
    logic solved_reg;

    wire setup = psel & ~penable;
    wire access = psel & penable & ready_reg;
    wire hit_ctrl = paddr == ftbs_pkg::CTRL_OFS;
    wire hit_ev = paddr == ftbs_pkg::EVENT_OFS;
    wire hit_stat = paddr == ftbs_pkg::STATUS_OFS;
    wire hit_el = paddr == ftbs_pkg::ELAPSED_OFS;
    wire hit_hist = paddr == ftbs_pkg::HIST_OFS;
    wire hit_any = hit_ctrl | hit_ev | hit_stat | hit_el | hit_hist;
    wire wr_ctrl = access & pwrite & hit_ctrl;
    wire wr_ev = access & pwrite & hit_ev;

    // read mux; the event register reads as zero
    wire [31:0] rd_mux =
        hit_ctrl ? {30'h0, ctrl_reg} :
        hit_stat ? {21'h0, base_reg} :
        hit_el ? {{(32 - TW){1'b0}}, el_reg} :
        hit_hist ? {27'h0, solved_reg, hist_reg} : 32'h0;

    // answer set up in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= '0;
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            ready_reg <= setup;
            err_reg <= setup & ~hit_any;
            rdata_reg <= (setup & ~pwrite) ? rd_mux : rdata_reg;
        end
    end

    // control levels and event pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= ftbs_pkg::CTRL_RESET;
            ev_reg <= '0;
        end else begin
            ctrl_reg <= wr_ctrl ? pwdata[1:0] : ctrl_reg;
            ev_reg <= wr_ev ? pwdata[4:0] : 5'h0;
        end
    end

    wire ob_arm = ctrl_reg[ftbs_pkg::CTRL_OB_ARM_BIT];
    wire ox_arm = ctrl_reg[ftbs_pkg::CTRL_OX_ARM_BIT];
    wire ev_solved = ev_reg[ftbs_pkg::EV_SOLVED_BIT];
    wire ev_alt6 = ev_reg[ftbs_pkg::EV_ALT6_DONE_BIT];
    wire ev_vel = ev_reg[ftbs_pkg::EV_VEL_CUT_BIT];
    wire ev_eng = ev_reg[ftbs_pkg::EV_ENG_CUT_BIT];
    wire ev_loss = ev_reg[ftbs_pkg::EV_THRUST_LOSS_BIT];

    // =========================================================
    // elapsed counters: this base, since base 5, base 6, solution
    logic [TW-1:0] t5_reg;
    logic [TW-1:0] t6_reg;
    logic [TW-1:0] cv_reg;
    logic vote;

    wire start = base_next != base_reg;
    wire in5 = start & (base_next == ftbs_pkg::FTBS_B5);
    wire in6 = start & (base_next == ftbs_pkg::FTBS_B6)
               & (base_reg == ftbs_pkg::FTBS_B5);

    // clear on entry; return from alt 6 keeps base 6 time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            el_reg <= '0;
            t5_reg <= '0;
            t6_reg <= '0;
            cv_reg <= '0;
        end else begin
            el_reg <= start ? '0 : ftbs_count(el_reg, tick_reg);    // [R19]
            t5_reg <= in5 ? '0 : ftbs_count(t5_reg, tick_reg);
            t6_reg <= in6 ? '0 : ftbs_count(t6_reg, tick_reg);
            cv_reg <= (ev_solved & ~solved_reg) ? '0
                      : ftbs_count(cv_reg, tick_reg);
        end
    end

    // =========================================================
    // two-of-four vote, cleared at each base start
    wire own_cut = (base_reg == ftbs_pkg::FTBS_B4 ||
                    base_reg == ftbs_pkg::FTBS_B4A) ? ev_vel : ev_eng;

    ftbs_vote #(
        .N(4)
    ) u_vote (
        .pclk(pclk),
        .presetn(presetn),
        .clear(start),                                  // [R20]
        .in_set({ev_loss, own_cut, eo_b, eo_a}),
        .vote(vote)
    );

    // =========================================================
    // start conditions
    wire started6 = hist_reg[0];
    wire started7 = hist_reg[1];
    wire started8 = hist_reg[2];
    wire started8a = hist_reg[3];
    wire settled = ftbs_reached(el_reg, SETTLE_TENTHS);
    wire go3 = ob_cut & ob_arm;                                     // [R18]
    wire go4 = ox_arm & (s2_cut | s2_out);                          // [R1]
    wire go4a = sep_any
                & ftbs_reached(el_reg, ftbs_pkg::SEP_HOLD_TENTHS);  // [R3] [R4]
    wire go6 = solved_reg & ~inhibit
               & ftbs_reached(el_reg, RESTART_TENTHS);              // [R7]
    wire go8a = ~started6 & ~inhibit & solved_reg
                & ftbs_reached(cv_reg, ALT8_TENTHS);                // [R12] [R13]
    wire go9_t5 = ~started6 & ~started8 & ~started8a & ~inhibit
                  & ftbs_reached(t5_reg, NINTH_T5_TENTHS);          // [R16]
    wire go6a = burner
                & ftbs_reached(t6_reg, ftbs_pkg::BURNER_LO_TENTHS)
                & ~ftbs_reached(t6_reg, ftbs_pkg::BURNER_HI_TENTHS + 1);
    wire go8 = started7 & ~inhibit
               & ftbs_reached(t6_reg, EIGHTH_TENTHS);               // [R11]
    wire go9_t6 = started7 & ~started8 & ~inhibit
                  & ftbs_reached(t6_reg, NINTH_T6_TENTHS);          // [R15]

    // next base; only these qualified starts change it
    always_comb begin
        base_next = base_reg;
        case (base_reg)
            ftbs_pkg::FTBS_PRE: begin
                if (go3) base_next = ftbs_pkg::FTBS_B3;
            end
            ftbs_pkg::FTBS_B3: begin
                if (go4) base_next = ftbs_pkg::FTBS_B4;
                else if (go4a) base_next = ftbs_pkg::FTBS_B4A;
            end
            ftbs_pkg::FTBS_B4, ftbs_pkg::FTBS_B4A: begin
                if (vote) base_next = ftbs_pkg::FTBS_B5;            // [R5]
            end
            ftbs_pkg::FTBS_B5: begin
                if (go6) base_next = ftbs_pkg::FTBS_B6;
                else if (go8a) base_next = ftbs_pkg::FTBS_B8A;
                else if (go9_t5) base_next = ftbs_pkg::FTBS_B9;
            end
            ftbs_pkg::FTBS_B6: begin
                if (go6a) base_next = ftbs_pkg::FTBS_B6A;           // [R8]
                else if (settled & vote) base_next = ftbs_pkg::FTBS_B7; // [R9]
            end
            ftbs_pkg::FTBS_B6A: begin
                if (ev_alt6) base_next = ftbs_pkg::FTBS_B6;         // [R8]
            end
            ftbs_pkg::FTBS_B7: begin
                if (go8) base_next = ftbs_pkg::FTBS_B8;
                else if (go9_t6) base_next = ftbs_pkg::FTBS_B9;
            end
            ftbs_pkg::FTBS_B8, ftbs_pkg::FTBS_B8A: begin
                if (settled & vote) base_next = ftbs_pkg::FTBS_B9;  // [R14]
            end
            ftbs_pkg::FTBS_B9: begin
                base_next = ftbs_pkg::FTBS_B9;
            end
            default: begin
                base_next = ftbs_pkg::FTBS_PRE;
            end
        endcase
    end

    // =========================================================
    // base register, history and redundant cutoff pulses
    wire to4 = start & (base_next == ftbs_pkg::FTBS_B4);
    wire to7 = start & (base_next == ftbs_pkg::FTBS_B7);
    wire to8 = start & (base_next == ftbs_pkg::FTBS_B8);
    wire to8a = start & (base_next == ftbs_pkg::FTBS_B8A);
    wire to9 = start & (base_next == ftbs_pkg::FTBS_B9);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_reg <= ftbs_pkg::FTBS_PRE;
            hist_reg <= '0;
            solved_reg <= 1'b0;
            s2_cutoff_cmd <= 1'b0;
            s3_cutoff_cmd <= 1'b0;
            base_start <= 1'b0;
        end else begin
            base_reg <= base_next;                                  // [R19]
            hist_reg <= hist_reg | {to8a, to8, to7, in6};
            solved_reg <= solved_reg | ev_solved;
            s2_cutoff_cmd <= to4;                                   // [R2]
            s3_cutoff_cmd <= in5 | to7 | to9;                       // [R6] [R10] [R17]
            base_start <= start;
        end
    end

    // the cutoff pulses and base_start line up with base_onehot
    assign base_onehot = base_reg;
    assign prdata = rdata_reg;
    assign pready = ready_reg;
    assign pslverr = err_reg;

endmodule

// *** verification/ftbs_seq_sva.sv ***
// Purpose: port checks of the sequencer
// Assumes: bound to ftbs_sequencer, one clock domain
// Notes: watches design ports only: outputs except prdata and pslverr, plus psel and penable
`timescale 1ns/100ps
module ftbs_seq_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic s2_cutoff_cmd,
    input wire logic s3_cutoff_cmd,
    input wire logic base_start,
    input wire logic [10:0] base_onehot
);
    // ==================================================
    // helpers: bases that repeat the s3 cutoff
    logic s3_base;
    assign s3_base = base_onehot[4] | base_onehot[7] | base_onehot[10];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==================================================
    // base and pready checks
    a_one_base: assert property ($onehot(base_onehot))
        else $error("base not one-hot");
    a_start_marks: assert property (
        base_onehot != $past(base_onehot) |-> base_start)
        else $error("base change, no start");
    a_b4_cutoff: assert property (
        $rose(base_onehot[2]) |-> s2_cutoff_cmd && $past(base_onehot[1]))
        else $error("base 4, no s2 cutoff");
    a_s2_only_b4: assert property (
        s2_cutoff_cmd |-> base_onehot[2] && base_start ##1 !s2_cutoff_cmd)
        else $error("stray s2 cutoff");
    a_s3_cutoff: assert property (
        base_start && s3_base |-> s3_cutoff_cmd)
        else $error("no s3 cutoff");
    a_s3_cause: assert property (
        s3_cutoff_cmd |-> base_start && s3_base ##1 !s3_cutoff_cmd)
        else $error("stray s3 cutoff");
    a_b5_order: assert property (
        $rose(base_onehot[4]) |-> $past(base_onehot[2] | base_onehot[3]))
        else $error("bad base 5 entry");
    a_b6a_return: assert property (
        $fell(base_onehot[6]) |-> base_onehot[5] && base_start)
        else $error("bad alt 6 exit");
    a_b8_after7: assert property (
        $rose(base_onehot[8]) |-> $past(base_onehot[7]))
        else $error("base 8 without 7");
    a_b9_from: assert property (
        $rose(base_onehot[10]) |-> $past(base_onehot[4] |
        base_onehot[7] | base_onehot[8] | base_onehot[9]))
        else $error("bad base 9 entry");
    a_pready_once: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle");
endmodule

bind ftbs_sequencer ftbs_seq_sva u_sva (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .s2_cutoff_cmd(s2_cutoff_cmd),
    .s3_cutoff_cmd(s3_cutoff_cmd),
    .base_start(base_start),
    .base_onehot(base_onehot)
);

// *** verification/ftbs_stage_model.sv ***
// Purpose: stage side: status contacts and cutoff decoders
// Assumes: bench sets requests just after a rising edge
// Notes: contacts follow requests one edge late
`timescale 1ns/100ps
module ftbs_stage_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [8:0] req,
    input wire logic s2_cutoff_cmd,
    input wire logic s3_cutoff_cmd,
    output logic [8:0] pins,
    output logic [7:0] s2_cmds,
    output logic [7:0] s3_cmds
);
    // ==================================================
    // contacts and cutoff counters
    // counts let the bench judge one-cycle pulses later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins <= 9'h0;
            s2_cmds <= 8'h0;
            s3_cmds <= 8'h0;
        end else begin
            pins <= req;
            s2_cmds <= s2_cmds + {7'h0, s2_cutoff_cmd};
            s3_cmds <= s3_cmds + {7'h0, s3_cutoff_cmd};
        end
    end
endmodule

// *** verification/ftbs_sequencer_tb.sv ***
// Purpose: bench of the sequencer
// Assumes: short tick and windows by parameter
// Notes: main chain, then early staging to base 9
`timescale 1ns/100ps
`define CHK(n, e, a) begin \
    checks++; \
    if ((a) !== (e)) begin \
        fails++; \
        $display("CHECK FAILED %s expected %0h seen %0h", n, e, a); \
    end \
end
module ftbs_sequencer_tb;
    localparam int TK = 4;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [8:0] req, pins;
    logic s2c, s3c, bst;
    logic [10:0] base;
    logic [7:0] s2n, s3n;
    int fails = 0;
    int checks = 0;
    int cyc = 0;

    always #2.5 pclk = ~pclk;

    ftbs_sequencer #(
        .TICK_CYCLES(TK),
        .RESTART_TENTHS(20),
        .EIGHTH_TENTHS(5),
        .ALT8_TENTHS(6),
        .NINTH_T5_TENTHS(30),
        .SETTLE_TENTHS(3)
    ) dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ob_cutoff_in(pins[0]),
        .s2_cutoff_in(pins[1]),
        .s2_engines_out_in(pins[2]),
        .sep_req_a_in(pins[3]),
        .sep_req_b_in(pins[4]),
        .engine_out_a_in(pins[5]),
        .engine_out_b_in(pins[6]),
        .burner_fault_in(pins[7]),
        .restart_inhibit_in(pins[8]),
        .s2_cutoff_cmd(s2c),
        .s3_cutoff_cmd(s3c),
        .base_start(bst),
        .base_onehot(base)
    );

    ftbs_stage_model stage (
        .pclk(pclk),
        .presetn(presetn),
        .req(req),
        .s2_cutoff_cmd(s2c),
        .s3_cutoff_cmd(s3c),
        .pins(pins),
        .s2_cmds(s2n),
        .s3_cmds(s3n)
    );

    // ==================================================
    // closing report and hang guard
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // run needs about 2500 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            end_sim();
        end
    end

    // ==================================================
    // apb master and helpers, all entered just after an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic xe, input string n);
        apb(1'b0, a, 32'h0);
        `CHK(n, x, q)
        `CHK("pslverr", xe, e)
    endtask

    task automatic ev(input int b);
        apb(1'b1, ftbs_pkg::EVENT_OFS, 32'h1 << b);
    endtask

    task automatic pin(input int p, input logic v);
        req[p] <= v;
    endtask

    task automatic hold(input logic [10:0] x, input int n, input string s);
        repeat (n) @(posedge pclk);
        `CHK(s, x, base)
    endtask

    task automatic wait_base(input logic [10:0] x, input int lim,
                             input string n);
        int k;
        k = 0;
        while (base !== x && k < lim) begin
            @(negedge pclk);
            k++;
        end
        `CHK(n, x, base)
        repeat (2) @(posedge pclk);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        req <= 9'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // ==================================================
    // scenarios
    task automatic t_regs();
        `CHK("reset base", 11'h001, base)
        rd(ftbs_pkg::CTRL_OFS, 32'h0, 1'b0, "ctrl reset");
        apb(1'b1, ftbs_pkg::STATUS_OFS, 32'h7ff);
        rd(ftbs_pkg::STATUS_OFS, 32'h1, 1'b0, "status ro");
        rd(ftbs_pkg::EVENT_OFS, 32'h0, 1'b0, "event rd");
        rd(8'h20, 32'h0, 1'b1, "unmapped");
        apb(1'b1, ftbs_pkg::CTRL_OFS, 32'h3);
        rd(ftbs_pkg::CTRL_OFS, 32'h3, 1'b0, "ctrl rw");
        apb(1'b1, ftbs_pkg::CTRL_OFS, 32'h0);
        $display("regs done");
    endtask

    // refusals, then base 4
    task automatic t_b3_b4();
        pin(ftbs_pkg::PIN_INHIBIT, 1'b1);
        pin(ftbs_pkg::PIN_OB_CUT, 1'b1);
        hold(11'h001, 12, "b3 unarmed");
        apb(1'b1, ftbs_pkg::CTRL_OFS, 32'h1);
        wait_base(11'h002, 6, "b3");
        pin(ftbs_pkg::PIN_OB_CUT, 1'b0);
        pin(ftbs_pkg::PIN_SEP_A, 1'b1);
        pin(ftbs_pkg::PIN_S2_CUT, 1'b1);
        hold(11'h002, 30, "early sep");
        pin(ftbs_pkg::PIN_SEP_A, 1'b0);
        hold(11'h002, 40, "ox unarmed");
        apb(1'b1, ftbs_pkg::CTRL_OFS, 32'h3);
        wait_base(11'h004, 4, "b4");
        `CHK("s2 cmds", 8'h1, s2n)
        pin(ftbs_pkg::PIN_S2_CUT, 1'b0);
        $display("b3 b4 done");
    endtask

    task automatic t_b5_b6();
        pin(ftbs_pkg::PIN_EO_A, 1'b1);
        hold(11'h004, 10, "one vote");
        ev(ftbs_pkg::EV_VEL_CUT_BIT);
        wait_base(11'h010, 4, "b5 vote");
        `CHK("s3 cmds", 8'h1, s3n)
        pin(ftbs_pkg::PIN_EO_A, 1'b0);
        ev(ftbs_pkg::EV_SOLVED_BIT);
        hold(11'h010, 160, "inhibit");
        pin(ftbs_pkg::PIN_INHIBIT, 1'b0);
        wait_base(11'h020, 6, "b6");
        $display("b5 b6 done");
    endtask

    task automatic t_b6a();
        pin(ftbs_pkg::PIN_BURNER, 1'b1);
        hold(11'h020, 40, "burner early");
        pin(ftbs_pkg::PIN_BURNER, 1'b0);
        repeat (480 * TK) @(posedge pclk);
        pin(ftbs_pkg::PIN_BURNER, 1'b1);
        wait_base(11'h040, 6, "b6a");
        pin(ftbs_pkg::PIN_BURNER, 1'b0);
        hold(11'h040, 6, "b6a holds");
        ev(ftbs_pkg::EV_ALT6_DONE_BIT);
        wait_base(11'h020, 4, "back to b6");
        $display("b6a done");
    endtask

    task automatic t_b7_b9();
        pin(ftbs_pkg::PIN_EO_A, 1'b1);
        ev(ftbs_pkg::EV_ENG_CUT_BIT);
        wait_base(11'h080, 30, "b7 vote");
        `CHK("s3 cmds", 8'h2, s3n)
        wait_base(11'h100, 4, "b8");
        pin(ftbs_pkg::PIN_EO_B, 1'b1);
        wait_base(11'h400, 30, "b9 vote");
        `CHK("s3 cmds", 8'h3, s3n)
        $display("b7 to b9 done");
    endtask

    // no solution, no inhibit: only the base 5 limit applies
    task automatic t_b4a_b9();
        do_reset();
        apb(1'b1, ftbs_pkg::CTRL_OFS, 32'h3);
        pin(ftbs_pkg::PIN_OB_CUT, 1'b1);
        wait_base(11'h002, 6, "b3 again");
        pin(ftbs_pkg::PIN_OB_CUT, 1'b0);
        repeat (15 * TK) @(posedge pclk);
        pin(ftbs_pkg::PIN_SEP_B, 1'b1);
        wait_base(11'h008, 6, "b4a");
        `CHK("s2 cmds", 8'h0, s2n)
        pin(ftbs_pkg::PIN_SEP_B, 1'b0);
        pin(ftbs_pkg::PIN_EO_B, 1'b1);
        ev(ftbs_pkg::EV_THRUST_LOSS_BIT);
        wait_base(11'h010, 6, "b5 from b4a");
        pin(ftbs_pkg::PIN_EO_B, 1'b0);
        hold(11'h010, 25 * TK, "b5 early");
        wait_base(11'h400, 8 * TK, "b9 time");
        `CHK("s3 cmds", 8'h2, s3n)
        $display("b4a done");
    endtask

    // ==================================================
    // main sequence
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        do_reset();
        t_regs();
        t_b3_b4();
        t_b5_b6();
        t_b6a();
        t_b7_b9();
        t_b4a_b9();
        end_sim();
    end
endmodule
